// ==== rtl/timer_pkg.sv ====
// Shared constants and types for the dual 8-bit timer block
package timer_pkg;

    // ------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int             ADDR_W              = 8;
    localparam logic [7:0]     IDX_TIMER2_CONTROL  = 8'h27;
    localparam logic [7:0]     IDX_TIMER0_CONTROL  = 8'h33;
    localparam logic [7:0]     IDX_COUNT0          = 8'h32;
    localparam logic [7:0]     IDX_COUNT2          = 8'h23;
    localparam logic [7:0]     IDX_COMPARE0        = 8'h31;
    localparam logic [7:0]     IDX_COMPARE2        = 8'h22;
    localparam logic [7:0]     IDX_PRESCALER_RESET = 8'h30;
    localparam logic [7:0]     IDX_ASYNC_CONTROL   = 8'h26;
    localparam logic [7:0]     IDX_FLAGS           = 8'h38;
    localparam logic [7:0]     IDX_MASK            = 8'h39;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int             FORCE_BIT           = 7;
    localparam int             SHARED_RESET_BIT    = 0;
    localparam int             T2_RESET_BIT        = 1;
    localparam int             ASYNC_SELECT_BIT    = 3;
    localparam int             FLAG_OVF0           = 0;
    localparam int             FLAG_CMP0           = 1;
    localparam int             FLAG_OVF2           = 2;
    localparam int             FLAG_CMP2           = 3;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [6:0]     CTRL_RESET          = 7'h00;
    localparam logic [7:0]     COUNT_RESET         = 8'h00;
    localparam logic [7:0]     COMPARE_RESET       = 8'h00;
    localparam logic [3:0]     FLAGS_RESET         = 4'h0;
    localparam logic [7:0]     COUNT_TOP           = 8'hff;
    localparam logic [7:0]     COUNT_BOTTOM        = 8'h00;
    localparam int             PRESCALE_W          = 10;

    // ------------------------------------------------------------
    // Prescaler tap positions (divide by two to the power)
    // ------------------------------------------------------------
    localparam int             TAP_DIV1            = 0;
    localparam int             TAP_DIV8            = 3;
    localparam int             TAP_DIV32           = 5;
    localparam int             TAP_DIV64           = 6;
    localparam int             TAP_DIV128          = 7;
    localparam int             TAP_DIV256          = 8;
    localparam int             TAP_DIV1024         = 10;

    // ------------------------------------------------------------
    // Compare output modes
    // ------------------------------------------------------------
    localparam logic [1:0]     COM_OFF             = 2'h0;
    localparam logic [1:0]     COM_TOGGLE          = 2'h1;
    localparam logic [1:0]     COM_CLEAR           = 2'h2;
    localparam logic [1:0]     COM_SET             = 2'h3;

    // Control register fields below the force bit
    typedef struct packed {
        logic       pwm_enable;
        logic [1:0] compare_output_mode;
        logic       clear_on_match;
        logic [2:0] clock_select;
    } unit_ctrl_s;

endpackage : timer_pkg

// ==== rtl/pin_sync2.sv ====
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Pins
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : pin_sync2
`default_nettype wire

// ==== rtl/tick_prescaler.sv ====
// Ripple-free divider chain with power-of-two tick taps
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Control
    input  wire logic       i_tick,
    input  wire logic       i_clear,
    // Taps
    output logic      [W:0] o_tap
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= '0;
        end else if (i_clear) begin
            cnt_ff <= '0;
        end else if (i_tick) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign o_tap[0] = i_tick & ~i_clear;
    for (genvar k = 1; k <= W; k++) begin : g_tap
        assign o_tap[k] = i_tick & ~i_clear & (&cnt_ff[k-1:0]);
    end
endmodule : tick_prescaler
`default_nettype wire

// ==== rtl/dual_timer.sv ====
// Two 8-bit timer/counters with prescalers behind an Avalon-MM slave
//
// Overview of operation
// - Shared prescaler taps 8,64,256,1024, CK, external, stop
// - Shared prescaler reset strobe, self clears, reads zero
// - Timer 2 reset reads one until async reset done
// - Writing zero to reset bits does nothing
// - Async select moves timer 2 clock to oscillator
// - External count pin sampled on CPU clock
// - Timer 2 source: clock, prescaled clock, oscillator
// - Force compare acts, no flag, no clear
// - Mode written with force applies next match
// - Force reads zero, ignored in PWM mode
// - PWM enable bit selects PWM operation
// - Compare mode: off, toggle, low, high
// - Clear on match zeroes counter after match
// - PWM: up/down, or wrap at top 0xff
// - Overflow and compare flags with mask register
// - Upper six reset register bits read zero
// - Timer 0 clock select encoding
// - Timer 2 clock select encoding
// - Flag one clock after match; write blocks match
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dual_timer (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Pins
    input  wire logic        i_external_count_pin,
    input  wire logic        i_osc_in_pin,
    output logic      [1:0]  o_compare_output_pin,
    output logic      [1:0]  o_compare_output_en,
    output logic             o_osc_pins_detached,
    // Flag requests
    output logic      [3:0]  o_event_req
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        ack_ff;
    logic        req;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_mux;
    logic [31:0] readdata_ff;

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_ff;
    assign wr_en   = i_avs_write & ack_ff & i_avs_byteenable[0];
    assign wr_data = i_avs_writedata[7:0];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            readdata_ff <= 32'h0;
        end else if (i_avs_read && !ack_ff) begin
            readdata_ff <= {24'h0, rd_mux};
        end
    end

    assign o_avs_readdata = readdata_ff;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [1:0] pin_sync;
    logic [1:0] pin_prev_ff;
    logic       ext_rise;
    logic       ext_fall;
    logic       osc_rise;

    pin_sync2 #(
        .W       (2)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async ({i_osc_in_pin, i_external_count_pin}),
        .o_sync  (pin_sync)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_prev_ff <= 2'h0;
        end else begin
            pin_prev_ff <= pin_sync;
        end
    end

    assign ext_rise = pin_sync[0] & ~pin_prev_ff[0];
    assign ext_fall = ~pin_sync[0] & pin_prev_ff[0];
    assign osc_rise = pin_sync[1] & ~pin_prev_ff[1];

    // ------------------------------------------------------------
    // Prescaler control
    // ------------------------------------------------------------
    logic async_sel_ff;
    logic t2_pending_ff;
    logic wr_reset_reg;
    logic shared_clear;
    logic t2_clear;
    logic t2_src_tick;
    logic [timer_pkg::PRESCALE_W:0] shared_tap;
    logic [timer_pkg::PRESCALE_W:0] t2_tap;

    assign wr_reset_reg = wr_en &&
                          (i_avs_address == timer_pkg::IDX_PRESCALER_RESET);
    // Only a one starts a reset
    assign shared_clear = wr_reset_reg &
                          wr_data[timer_pkg::SHARED_RESET_BIT];
    assign t2_clear = (wr_reset_reg & wr_data[timer_pkg::T2_RESET_BIT] &
                       ~async_sel_ff)
                    | (t2_pending_ff & osc_rise);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            async_sel_ff <= 1'b0;
        end else if (wr_en &&
                     i_avs_address == timer_pkg::IDX_ASYNC_CONTROL) begin
            async_sel_ff <= wr_data[timer_pkg::ASYNC_SELECT_BIT];
        end
    end

    // Pending until an oscillator edge performs the reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            t2_pending_ff <= 1'b0;
        end else if (wr_reset_reg && wr_data[timer_pkg::T2_RESET_BIT] &&
                     async_sel_ff) begin
            t2_pending_ff <= 1'b1;
        end else if (osc_rise || !async_sel_ff) begin
            t2_pending_ff <= 1'b0;
        end
    end

    assign t2_src_tick         = async_sel_ff ? osc_rise : 1'b1;
    assign o_osc_pins_detached = async_sel_ff;

    tick_prescaler #(
        .W       (timer_pkg::PRESCALE_W)
    ) u_shared_prescaler (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_tick  (1'b1),
        .i_clear (shared_clear),
        .o_tap   (shared_tap)
    );

    tick_prescaler #(
        .W       (timer_pkg::PRESCALE_W)
    ) u_t2_prescaler (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_tick  (t2_src_tick),
        .i_clear (t2_clear),
        .o_tap   (t2_tap)
    );

    // ------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------
    timer_pkg::unit_ctrl_s ctrl_ff [2];
    logic [1:0] unit_tick;

    always_comb begin
        unique case (ctrl_ff[0].clock_select)
            3'h0: unit_tick[0] = 1'b0;
            3'h1: unit_tick[0] = shared_tap[timer_pkg::TAP_DIV1];
            3'h2: unit_tick[0] = shared_tap[timer_pkg::TAP_DIV8];
            3'h3: unit_tick[0] = shared_tap[timer_pkg::TAP_DIV64];
            3'h4: unit_tick[0] = shared_tap[timer_pkg::TAP_DIV256];
            3'h5: unit_tick[0] = shared_tap[timer_pkg::TAP_DIV1024];
            3'h6: unit_tick[0] = ext_fall;
            3'h7: unit_tick[0] = ext_rise;
        endcase
    end

    always_comb begin
        unique case (ctrl_ff[1].clock_select)
            3'h0: unit_tick[1] = 1'b0;
            3'h1: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV1];
            3'h2: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV8];
            3'h3: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV32];
            3'h4: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV64];
            3'h5: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV128];
            3'h6: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV256];
            3'h7: unit_tick[1] = t2_tap[timer_pkg::TAP_DIV1024];
        endcase
    end

    // ------------------------------------------------------------
    // Timer units (index 0 is unit 0, index 1 is unit 2)
    // ------------------------------------------------------------
    logic [7:0] cnt_ff [2];
    logic [7:0] ocr_ff [2];
    logic [1:0] oc_ff;
    logic [1:0] down_ff;
    logic [1:0] block_ff;
    logic [1:0] ovf_evt;
    logic [1:0] cmp_evt;

    for (genvar u = 0; u < 2; u++) begin : g_unit
        localparam logic [7:0] CTRL_IDX = (u == 0) ?
            timer_pkg::IDX_TIMER0_CONTROL : timer_pkg::IDX_TIMER2_CONTROL;
        localparam logic [7:0] CNT_IDX  = (u == 0) ?
            timer_pkg::IDX_COUNT0 : timer_pkg::IDX_COUNT2;
        localparam logic [7:0] OCR_IDX  = (u == 0) ?
            timer_pkg::IDX_COMPARE0 : timer_pkg::IDX_COMPARE2;

        logic       wr_ctrl;
        logic       wr_cnt;
        logic       force_act;
        logic       match;
        logic       updown;
        logic       wrap_pwm;
        logic       at_top;
        logic       at_bottom;
        logic [7:0] nxt_cnt;
        logic       nxt_oc;

        assign wr_ctrl   = wr_en && (i_avs_address == CTRL_IDX);
        assign wr_cnt    = wr_en && (i_avs_address == CNT_IDX);
        assign updown    = ctrl_ff[u].pwm_enable &
                           ~ctrl_ff[u].clear_on_match;
        assign wrap_pwm  = ctrl_ff[u].pwm_enable &
                           ctrl_ff[u].clear_on_match;
        assign at_top    = cnt_ff[u] == timer_pkg::COUNT_TOP;
        assign at_bottom = cnt_ff[u] == timer_pkg::COUNT_BOTTOM;
        assign force_act = wr_ctrl & wr_data[timer_pkg::FORCE_BIT] &
                           ~ctrl_ff[u].pwm_enable;
        assign match     = unit_tick[u] & (cnt_ff[u] == ocr_ff[u]) &
                           ~block_ff[u];
        assign ovf_evt[u] = unit_tick[u] & ~wr_cnt &
                            (updown ? (down_ff[u] & at_bottom)
                                    : at_top);
        assign cmp_evt[u] = match;

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                ctrl_ff[u] <= timer_pkg::CTRL_RESET;
            end else if (wr_ctrl) begin
                ctrl_ff[u] <= timer_pkg::unit_ctrl_s'(wr_data[6:0]);
            end
        end

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                ocr_ff[u] <= timer_pkg::COMPARE_RESET;
            end else if (wr_en && i_avs_address == OCR_IDX) begin
                ocr_ff[u] <= wr_data;
            end
        end

        // Write blocks the match of the next timer tick
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                block_ff[u] <= 1'b0;
            end else if (wr_cnt) begin
                block_ff[u] <= 1'b1;
            end else if (unit_tick[u]) begin
                block_ff[u] <= 1'b0;
            end
        end

        always_comb begin
            nxt_cnt = cnt_ff[u];
            if (wr_cnt) begin
                nxt_cnt = wr_data;
            end else if (unit_tick[u]) begin
                if (updown) begin
                    if (down_ff[u]) begin
                        nxt_cnt = at_bottom ? 8'h01 : cnt_ff[u] - 8'h01;
                    end else begin
                        nxt_cnt = at_top ? 8'hfe : cnt_ff[u] + 8'h01;
                    end
                end else if (!ctrl_ff[u].pwm_enable &&
                             ctrl_ff[u].clear_on_match && match) begin
                    nxt_cnt = timer_pkg::COUNT_BOTTOM;
                end else begin
                    nxt_cnt = cnt_ff[u] + 8'h01;
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                cnt_ff[u] <= timer_pkg::COUNT_RESET;
            end else begin
                cnt_ff[u] <= nxt_cnt;
            end
        end

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                down_ff[u] <= 1'b0;
            end else if (!updown) begin
                down_ff[u] <= 1'b0;
            end else if (unit_tick[u] && !wr_cnt) begin
                if (!down_ff[u] && at_top) begin
                    down_ff[u] <= 1'b1;
                end else if (down_ff[u] && at_bottom) begin
                    down_ff[u] <= 1'b0;
                end
            end
        end

        // Old mode applies on a force written with a new mode
        always_comb begin
            nxt_oc = oc_ff[u];
            if (!ctrl_ff[u].pwm_enable) begin
                if (match || force_act) begin
                    unique case (ctrl_ff[u].compare_output_mode)
                        timer_pkg::COM_OFF:    nxt_oc = oc_ff[u];
                        timer_pkg::COM_TOGGLE: nxt_oc = ~oc_ff[u];
                        timer_pkg::COM_CLEAR:  nxt_oc = 1'b0;
                        timer_pkg::COM_SET:    nxt_oc = 1'b1;
                    endcase
                end
            end else if (ctrl_ff[u].compare_output_mode[1]) begin
                if (match) begin
                    nxt_oc = ctrl_ff[u].compare_output_mode[0] ^
                             (updown & down_ff[u]);
                end else if (wrap_pwm && ovf_evt[u]) begin
                    nxt_oc = ~ctrl_ff[u].compare_output_mode[0];
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                oc_ff[u] <= 1'b0;
            end else begin
                oc_ff[u] <= nxt_oc;
            end
        end

        assign o_compare_output_en[u] = ctrl_ff[u].pwm_enable ?
            ctrl_ff[u].compare_output_mode[1] :
            (ctrl_ff[u].compare_output_mode != timer_pkg::COM_OFF);
    end

    assign o_compare_output_pin = oc_ff;

    // ------------------------------------------------------------
    // Flag and mask registers
    // ------------------------------------------------------------
    logic [3:0] flags_ff;
    logic [3:0] mask_ff;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;

    assign flag_set = {cmp_evt[1], ovf_evt[1], cmp_evt[0], ovf_evt[0]};
    assign flag_clr = (wr_en && i_avs_address == timer_pkg::IDX_FLAGS) ?
                      wr_data[3:0] : 4'h0;

    // Hardware set wins over a software clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_ff <= timer_pkg::FLAGS_RESET;
        end else begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_ff <= timer_pkg::FLAGS_RESET;
        end else if (wr_en && i_avs_address == timer_pkg::IDX_MASK) begin
            mask_ff <= wr_data[3:0];
        end
    end

    assign o_event_req = flags_ff & mask_ff;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        unique case (i_avs_address)
            timer_pkg::IDX_TIMER0_CONTROL: rd_mux = {1'b0, ctrl_ff[0]};
            timer_pkg::IDX_TIMER2_CONTROL: rd_mux = {1'b0, ctrl_ff[1]};
            timer_pkg::IDX_COUNT0:         rd_mux = cnt_ff[0];
            timer_pkg::IDX_COUNT2:         rd_mux = cnt_ff[1];
            timer_pkg::IDX_COMPARE0:       rd_mux = ocr_ff[0];
            timer_pkg::IDX_COMPARE2:       rd_mux = ocr_ff[1];
            timer_pkg::IDX_PRESCALER_RESET:
                rd_mux = {6'h00, t2_pending_ff, 1'b0};
            timer_pkg::IDX_ASYNC_CONTROL:
                rd_mux = {4'h0, async_sel_ff, 3'h0};
            timer_pkg::IDX_FLAGS:          rd_mux = {4'h0, flags_ff};
            timer_pkg::IDX_MASK:           rd_mux = {4'h0, mask_ff};
            default:                       rd_mux = 8'h00;
        endcase
    end

endmodule : dual_timer
`default_nettype wire

// ==== sim/timer_sva.sv ====
// Port assertions for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module timer_sva (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Bus
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] o_avs_readdata,
    input  wire logic        o_avs_waitrequest,
    // Pins
    input  wire logic [1:0]  o_compare_output_en,
    input  wire logic        o_osc_pins_detached
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic        wok;
    logic        rok;
    logic        a30;
    logic        a26;
    logic        a33;
    logic        a27;
    logic [7:0]  d;
    assign wok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    assign rok = i_avs_read && !o_avs_waitrequest;
    assign a30 = i_avs_address == timer_pkg::IDX_PRESCALER_RESET;
    assign a26 = i_avs_address == timer_pkg::IDX_ASYNC_CONTROL;
    assign a33 = i_avs_address == timer_pkg::IDX_TIMER0_CONTROL;
    assign a27 = i_avs_address == timer_pkg::IDX_TIMER2_CONTROL;
    assign d   = i_avs_writedata[7:0];
    rst_reads_zero_a: assert property (rok && a30 |->
        o_avs_readdata[7:2] == 6'h00 && !o_avs_readdata[0])
        else $error("reset register reads nonzero");
    force_reads_zero_a: assert property (rok && (a33 || a27)
        |-> !o_avs_readdata[7]) else $error("force bit reads one");
    t2_rst_sync_a: assert property (rok && a30
        && !o_osc_pins_detached |-> !o_avs_readdata[1])
        else $error("timer2 reset reads one");
    detach_set_a: assert property (wok && a26 |=>
        o_osc_pins_detached == $past(d[3])) else $error("detach wrong");
    detach_hold_a: assert property (!(wok && a26) |=>
        $stable(o_osc_pins_detached)) else $error("detach moved");
    en0_mode_a: assert property (wok && a33 |=>
        o_compare_output_en[0] ==
        ($past(d[6]) ? $past(d[5]) : $past(d[5:4]) != 2'h0))
        else $error("unit0 pin enable wrong");
    en2_mode_a: assert property (wok && a27 |=>
        o_compare_output_en[1] ==
        ($past(d[6]) ? $past(d[5]) : $past(d[5:4]) != 2'h0))
        else $error("unit2 pin enable wrong");
    en_hold_a: assert property (!(wok && (a33 || a27)) |=>
        $stable(o_compare_output_en)) else $error("pin enable moved");
    cover property (rok && a30);
    cover property (wok && a26);
    cover property ($rose(o_compare_output_en[0]));
endmodule : timer_sva
bind dual_timer timer_sva u_sva (.i_clk, .i_rstn, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_compare_output_en,
    .o_osc_pins_detached);
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        cpin = 1'b0;
    logic        osc = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rq;
    logic        wtq;
    logic [1:0]  pin;
    logic [1:0]  pen;
    logic        det;
    logic [3:0]  evt;
    int          err_total = 0;
    int          checks_done = 0;
    always #2 i_clk = ~i_clk;
    dual_timer uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wtq), .i_external_count_pin(cpin),
        .i_osc_in_pin(osc), .o_compare_output_pin(pin),
        .o_compare_output_en(pen), .o_osc_pins_detached(det),
        .o_event_req(evt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] dv);
        int n;
        n = 0;
        @(posedge i_clk);
        adr <= a;
        wd <= {24'h0, dv};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge i_clk);
            n++;
        end while (wtq !== 1'b0 && n < 50);
        if (n >= 50) err_total++;
        rq = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rq, exp);
    endtask : rc
    task automatic t_reset;
        rc(8'h33, 32'h0);
        rc(8'h27, 32'h0);
        rc(8'h30, 32'h0);
        rc(8'h55, 32'h0);
        chk({30'h0, pin}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_force;
        bus(1'b1, 8'h33, 8'h10);
        bus(1'b1, 8'h33, 8'h90);
        @(posedge i_clk);
        chk({31'h0, pin[0]}, 32'h1);
        rc(8'h33, 32'h10);
        bus(1'b1, 8'h33, 8'hb0);
        @(posedge i_clk);
        chk({31'h0, pin[0]}, 32'h0);
        rc(8'h38, 32'h0);
        $display("test force done");
    endtask : t_force
    task automatic t_psr;
        bus(1'b1, 8'h30, 8'hff);
        rc(8'h30, 32'h0);
        bus(1'b1, 8'h26, 8'h08);
        @(posedge i_clk);
        chk({31'h0, det}, 32'h1);
        bus(1'b1, 8'h30, 8'h02);
        bus(1'b1, 8'h30, 8'h00);
        rc(8'h30, 32'h2);
        osc <= 1'b1;
        repeat (8) @(posedge i_clk);
        osc <= 1'b0;
        repeat (8) @(posedge i_clk);
        rc(8'h30, 32'h0);
        bus(1'b1, 8'h26, 8'h00);
        $display("test prescaler reset done");
    endtask : t_psr
    task automatic t_ctc;
        bus(1'b1, 8'h31, 8'h05);
        bus(1'b1, 8'h32, 8'h00);
        bus(1'b1, 8'h38, 8'hff);
        bus(1'b1, 8'h33, 8'h39);
        repeat (40) @(posedge i_clk);
        bus(1'b0, 8'h32, 8'h00);
        chk(32'(rq[7:0] <= 8'h05), 32'h1);
        rc(8'h38, 32'h2);
        chk({31'h0, pin[0]}, 32'h1);
        bus(1'b1, 8'h39, 8'h02);
        @(posedge i_clk);
        chk({28'h0, evt}, 32'h2);
        chk({30'h0, pen}, 32'h1);
        bus(1'b1, 8'h39, 8'h00);
        $display("test clear on match done");
    endtask : t_ctc
    task automatic t_ovf;
        bus(1'b1, 8'h33, 8'h00);
        bus(1'b1, 8'h32, 8'hf0);
        bus(1'b1, 8'h38, 8'hff);
        bus(1'b1, 8'h33, 8'h01);
        repeat (40) @(posedge i_clk);
        bus(1'b0, 8'h38, 8'h00);
        chk(rq & 32'h1, 32'h1);
        $display("test overflow done");
    endtask : t_ovf
    task automatic t_ext;
        bus(1'b1, 8'h33, 8'h00);
        bus(1'b1, 8'h32, 8'h00);
        bus(1'b1, 8'h33, 8'h07);
        for (int k = 0; k < 3; k++) begin
            repeat (4) @(posedge i_clk);
            cpin <= 1'b1;
            repeat (4) @(posedge i_clk);
            cpin <= 1'b0;
        end
        repeat (6) @(posedge i_clk);
        rc(8'h32, 32'h3);
        bus(1'b1, 8'h33, 8'h00);
        $display("test external count done");
    endtask : t_ext
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_force();
        t_psr();
        t_ctc();
        t_ovf();
        t_ext();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
